// ===== design/hs_port.v
// The implementer's own choices: the register addresses and the APB slave port.
`include "hs_port_regs.vh"

module hs_port (
    // Clock and reset
    input  wire        pclk,
    input  wire        presetn,
    // APB slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata_ff,
    output reg         pready_ff,
    output reg         pslverr_ff,
    // General port lines
    input  wire [7:0]  general_port_lines_in,
    output wire [7:0]  general_port_lines_out,
    output wire [7:0]  general_port_lines_oe,
    output wire [7:0]  general_port_keep,
    // Port zero keepers
    input  wire [7:0]  port0_in,
    output wire [7:0]  port0_keep,
    // Port three lines
    input  wire        port3_line0,
    output wire        port3_line0_keep,
    input  wire        port3_line1,
    output reg         port3_line6_out_ff,
    output reg         port3_line6_oe_ff,
    // Comparator front end results
    input  wire        cmp_line1_gt_ref,
    input  wire        cmp_line2_gt_ref,
    output reg         cmp_enable_ff,
    output reg  [1:0]  cmp_result_out_ff,
    // Buffer mode controls
    output reg  [3:0]  port_low_emi_ff,
    output reg         osc_low_emi_ff,
    output reg         ext_timing_ff
);

// ================================================================
// Registers
reg [7:0] cfg_ff;
reg [7:0] dir_ff;
reg [7:0] out_ff;
reg [1:0] hsc_ff;

wire [7:0] hs_data;
wire       hs_line6;
wire       hs_avail;
wire       hs_busy;
wire [7:0] pin_q;
wire [7:0] unused_p0_out;
wire [7:0] unused_p0_oe;
wire       unused_l0_out;
wire       unused_l0_oe;

wire hs_en     = hsc_ff[`HSC_EN_BIT];
wire hs_out    = hs_en & ~dir_ff[7];
wire analog    = cfg_ff[`CFG_ANALOG_BIT];
wire od_global = cfg_ff[`CFG_OPEN_DRAIN_BIT];

// ================================================================
// APB decode
wire setup_ph = psel & ~penable;
wire access   = psel & penable & pready_ff;
wire wr_en    = access & pwrite;
wire rd_en    = access & ~pwrite;

reg        hit;
reg [31:0] rd_mux;

// Handshake line one in analog mode comes from the comparator
// Comparator replaces digital path
wire line1_val = analog ? cmp_line1_gt_ref : port3_line1;

always @* begin
    hit    = 1'b1;
    rd_mux = 32'h00000000;
    case (paddr)
        `PORT_CFG_OFS: rd_mux = {24'h000000, cfg_ff};
        `PORT_DIR_OFS: rd_mux = {24'h000000, dir_ff};
        `PORT_OUT_OFS: rd_mux = {24'h000000, out_ff};
        `PORT_IN_OFS:  rd_mux = {24'h000000, general_port_lines_in};
        `HS_CTRL_OFS:  rd_mux = {30'h00000000, hsc_ff};
        `STATUS_OFS: begin
            rd_mux[`ST_HS_OUT_BIT] = hs_out;
            rd_mux[`ST_AVAIL_BIT]  = hs_avail;
            rd_mux[`ST_BUSY_BIT]   = hs_busy;
            rd_mux[`ST_CMP1_BIT]   = analog & cmp_line1_gt_ref;
            rd_mux[`ST_CMP2_BIT]   = analog & cmp_line2_gt_ref;
        end
        `HS_DATA_OFS:  rd_mux = {24'h000000, hs_data};
        default:       hit    = 1'b0;
    endcase
end

// Answer is prepared in setup so the access phase has no wait state
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        pready_ff  <= 1'b0;
        pslverr_ff <= 1'b0;
        prdata_ff  <= 32'h00000000;
    end else begin
        pready_ff  <= setup_ph;
        pslverr_ff <= setup_ph & ~hit;
        prdata_ff  <= (setup_ph & ~pwrite & hit) ? rd_mux : 32'h00000000;
    end
end

// ================================================================
// Software settings
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        cfg_ff <= `PORT_CFG_RST;
        dir_ff <= `PORT_DIR_RST;
        out_ff <= `PORT_OUT_RST;
        hsc_ff <= `HS_CTRL_RST;
    end else if (wr_en) begin
        case (paddr)
            `PORT_CFG_OFS: cfg_ff <= pwdata[7:0];
            `PORT_DIR_OFS: dir_ff <= pwdata[7:0];
            `PORT_OUT_OFS: out_ff <= pwdata[7:0];
            `HS_CTRL_OFS:  hsc_ff <= pwdata[1:0];
            // Handshake data write also loads the output latch
            `HS_DATA_OFS:  out_ff <= pwdata[7:0];
            default:       cfg_ff <= cfg_ff;
        endcase
    end
end

wire hs_start = wr_en & (paddr == `HS_DATA_OFS);
wire hs_rdack = rd_en & (paddr == `HS_DATA_OFS);

// ================================================================
// Handshake engine
hs_engine u_hs (
    .pclk       (pclk),
    .presetn    (presetn),
    .hs_en      (hs_en),
    .out_mode   (hs_out),
    .ext_timing (hsc_ff[`HSC_EXT_BIT]),
    .start      (hs_start),
    .rd_ack     (hs_rdack),
    .pins_in    (general_port_lines_in),
    .data_ff    (hs_data),
    .line1_in   (line1_val),
    .line6_ff   (hs_line6),
    .avail_ff   (hs_avail),
    .busy_ff    (hs_busy)
);

// ================================================================
// Pad cells
genvar i;
generate
    for (i = 0; i < 8; i = i + 1) begin : g_line
        line_cell u_p2 (
            .pclk       (pclk),
            .presetn    (presetn),
            .is_input   (dir_ff[i]),
            .open_drain (od_global),
            .out_val    (out_ff[i]),
            .pin_in     (general_port_lines_in[i]),
            .pin_out_ff (general_port_lines_out[i]),
            .pin_oe_ff  (general_port_lines_oe[i]),
            .keep_ff    (general_port_keep[i])
        );
        line_cell u_p0 (
            .pclk       (pclk),
            .presetn    (presetn),
            .is_input   (1'b1),
            .open_drain (1'b0),
            .out_val    (1'b0),
            .pin_in     (port0_in[i]),
            .pin_out_ff (unused_p0_out[i]),
            .pin_oe_ff  (unused_p0_oe[i]),
            .keep_ff    (port0_keep[i])
        );
    end
endgenerate

// Line zero keeper; lines one and six have none
line_cell u_l0 (
    .pclk       (pclk),
    .presetn    (presetn),
    .is_input   (1'b1),
    .open_drain (1'b0),
    .out_val    (1'b0),
    .pin_in     (port3_line0),
    .pin_out_ff (unused_l0_out),
    .pin_oe_ff  (unused_l0_oe),
    .keep_ff    (port3_line0_keep)
);

assign pin_q = general_port_lines_in;

// ================================================================
// Port three, comparator and buffer modes
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        port3_line6_out_ff <= 1'b1;
        port3_line6_oe_ff  <= 1'b0;
        cmp_enable_ff      <= 1'b0;
        cmp_result_out_ff  <= 2'h0;
        port_low_emi_ff    <= 4'h0;
        osc_low_emi_ff     <= 1'b0;
        ext_timing_ff      <= 1'b0;
    end else begin
        // Line six driven only under handshake
        port3_line6_out_ff <= hs_line6;
        port3_line6_oe_ff  <= hs_en;
        cmp_enable_ff      <= analog;
        cmp_result_out_ff  <= (analog & cfg_ff[`CFG_CMP_OUT_BIT]) ?
                              {cmp_line2_gt_ref, cmp_line1_gt_ref} : 2'h0;
        port_low_emi_ff    <= cfg_ff[`CFG_EMI_P3_BIT:`CFG_EMI_P0_BIT];
        osc_low_emi_ff     <= cfg_ff[`CFG_EMI_OSC_BIT];
        ext_timing_ff      <= hsc_ff[`HSC_EXT_BIT];
    end
end

endmodule // hs_port

// ===== design/hs_port_regs.vh
`ifndef HS_PORT_REGS_VH
`define HS_PORT_REGS_VH

// ================================================================
// Register offsets (byte addresses)
`define PORT_CFG_OFS      8'h00
`define PORT_DIR_OFS      8'h04
`define PORT_OUT_OFS      8'h08
`define PORT_IN_OFS       8'h0c
`define HS_CTRL_OFS       8'h10
`define STATUS_OFS        8'h14
`define HS_DATA_OFS       8'h18

// ================================================================
// Port configuration register fields
`define CFG_CMP_OUT_BIT   0
`define CFG_OPEN_DRAIN_BIT 1
`define CFG_EMI_P0_BIT    2
`define CFG_EMI_P1_BIT    3
`define CFG_EMI_P2_BIT    4
`define CFG_EMI_P3_BIT    5
`define CFG_EMI_OSC_BIT   6
`define CFG_ANALOG_BIT    7

// Handshake control fields
`define HSC_EN_BIT        0
`define HSC_EXT_BIT       1

// Status fields
`define ST_HS_OUT_BIT     0
`define ST_AVAIL_BIT      1
`define ST_BUSY_BIT       2
`define ST_CMP1_BIT       3
`define ST_CMP2_BIT       4

// ================================================================
// Reset values
`define PORT_CFG_RST      8'h00
`define PORT_DIR_RST      8'hff
`define PORT_OUT_RST      8'h00
`define HS_CTRL_RST       2'h0

// ================================================================
// Timing counts in clock periods
`define HS_SETUP_CYC      4'h2
`define EXT_TIMING_CYC    4'h2

`endif

// ===== design/line_cell.v
`include "hs_port_regs.vh"

module line_cell (
    // Clock and reset
    input  wire pclk,
    input  wire presetn,
    // Control
    input  wire is_input,
    input  wire open_drain,
    input  wire out_val,
    // Pad
    input  wire pin_in,
    output reg  pin_out_ff,
    output reg  pin_oe_ff,
    output reg  keep_ff
);

// ================================================================
// Drive and keeper
// Open drain only ever drives low; high is left to the pull-up.
wire nxt_oe = ~is_input & (~open_drain | ~out_val);

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        pin_out_ff <= 1'b0;
        pin_oe_ff  <= 1'b0;
        keep_ff    <= 1'b0;
    end else begin
        pin_out_ff <= out_val;
        pin_oe_ff  <= nxt_oe;
        // Keeper follows the wire so a floating input stays at a valid level
        keep_ff    <= nxt_oe ? out_val : pin_in;
    end
end

endmodule // line_cell

// ===== design/hs_engine.v
`include "hs_port_regs.vh"

module hs_engine (
    // Clock and reset
    input  wire       pclk,
    input  wire       presetn,
    // Control
    input  wire       hs_en,
    input  wire       out_mode,
    input  wire       ext_timing,
    input  wire       start,
    input  wire       rd_ack,
    // Data
    input  wire [7:0] pins_in,
    output reg  [7:0] data_ff,
    // Handshake lines
    input  wire       line1_in,
    output reg        line6_ff,
    // Status
    output reg        avail_ff,
    output reg        busy_ff
);

localparam S_IDLE  = 2'd0;
localparam S_SETUP = 2'd1;
localparam S_WACK  = 2'd2;
localparam S_WREL  = 2'd3;

reg [1:0] state_ff;
reg [3:0] cnt_ff;

wire [3:0] setup_cyc = `HS_SETUP_CYC + (ext_timing ? `EXT_TIMING_CYC : 4'h0);

// ================================================================
// Handshake sequencer
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        state_ff <= S_IDLE;
        cnt_ff   <= 4'h0;
        data_ff  <= 8'h00;
        line6_ff <= 1'b1;
        avail_ff <= 1'b0;
        busy_ff  <= 1'b0;
    end else if (!hs_en) begin
        state_ff <= S_IDLE;
        line6_ff <= 1'b1;
        busy_ff  <= 1'b0;
        avail_ff <= avail_ff & ~rd_ack;
    end else if (!out_mode) begin
        state_ff <= S_IDLE;
        busy_ff  <= 1'b0;
        if (!line1_in && line6_ff == 1'b0 && !avail_ff) begin
            data_ff  <= pins_in;
            avail_ff <= 1'b1;
            line6_ff <= 1'b1;
        end else begin
            avail_ff <= avail_ff & ~rd_ack;
            // Ready again only once strobe released and data taken
            if (line1_in && !(avail_ff & ~rd_ack))
                line6_ff <= 1'b0;
        end
    end else begin
        avail_ff <= avail_ff & ~rd_ack;
        case (state_ff)
            S_IDLE: begin
                line6_ff <= 1'b1;
                if (start) begin
                    state_ff <= S_SETUP;
                    cnt_ff   <= setup_cyc;
                    busy_ff  <= 1'b1;
                end
            end
            S_SETUP: begin
                if (cnt_ff <= 4'h1) begin
                    state_ff <= S_WACK;
                    line6_ff <= 1'b0;
                end else begin
                    cnt_ff <= cnt_ff - 4'h1;
                end
            end
            S_WACK: begin
                if (!line1_in) begin
                    state_ff <= S_WREL;
                    line6_ff <= 1'b1;
                end
            end
            S_WREL: begin
                if (line1_in) begin
                    state_ff <= S_IDLE;
                    busy_ff  <= 1'b0;
                end
            end
            default: begin
                state_ff <= S_IDLE;
            end
        endcase
    end
end

endmodule // hs_engine

// ===== bench/hs_port_props.sv
`include "hs_port_regs.vh"

module hs_port_props (
    // Clock and reset
    input logic        pclk,
    input logic        presetn,
    // APB
    input logic        psel,
    input logic        penable,
    input logic        pwrite,
    input logic [7:0]  paddr,
    input logic [31:0] prdata_ff,
    input logic        pready_ff,
    input logic        pslverr_ff,
    // Pads and modes
    input logic [7:0]  general_port_lines_out,
    input logic [7:0]  general_port_lines_oe,
    input logic        port3_line1,
    input logic        port3_line6_out_ff,
    input logic        port3_line6_oe_ff,
    input logic        cmp_enable_ff,
    input logic [1:0]  cmp_result_out_ff,
    input logic [3:0]  port_low_emi_ff,
    input logic        osc_low_emi_ff,
    input logic        ext_timing_ff
);
    // ====================
    // Helpers
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic setup;
    logic wr_done;
    assign setup   = psel && !penable;
    assign wr_done = psel && penable && pwrite && pready_ff;

    // ====================
    // Properties
    a_ready_setup: assert property (setup |=> pready_ff)
        else $error("no ready after setup");
    a_ready_single: assert property (pready_ff |=> !pready_ff)
        else $error("ready held two cycles");
    a_cfg_mapped: assert property (setup && paddr == `PORT_CFG_OFS |=> pready_ff && !pslverr_ff)
        else $error("config register refused");
    a_unmapped_err: assert property (setup && paddr > `HS_DATA_OFS |=> pslverr_ff && prdata_ff == 32'h0)
        else $error("unmapped access not refused");
    a_rdata_idle: assert property (!pready_ff |-> prdata_ff == 32'h0 && !pslverr_ff)
        else $error("read data outside access");
    a_emi_by_write: assert property ($changed({port_low_emi_ff, osc_low_emi_ff, ext_timing_ff})
        |-> $past(wr_done) || $past(wr_done, 2)) else $error("mode changed without write");
    a_pad_by_write: assert property ($changed({general_port_lines_out, general_port_lines_oe, port3_line6_oe_ff})
        |-> $past(wr_done) || $past(wr_done, 2)) else $error("pad drive changed without write");
    // Strobe or acknowledge low must end the low phase of the handshake line
    a_ack_release: assert property (port3_line6_oe_ff && !port3_line6_out_ff && !port3_line1 && !cmp_enable_ff
        |-> ##[0:4] port3_line6_out_ff) else $error("handshake line not released");
    a_cmp_gated: assert property (cmp_result_out_ff != 2'b00 |-> cmp_enable_ff || $past(cmp_enable_ff))
        else $error("comparator result outside analog mode");
    a_reset_inputs: assert property ($rose(presetn) |-> general_port_lines_oe == 8'h00 && port3_line6_out_ff)
        else $error("lines driven after reset");

    c_write: cover property (wr_done);
    c_refused: cover property (pslverr_ff);
    c_ack: cover property (!port3_line6_out_ff && !port3_line1);
endmodule // hs_port_props

bind hs_port hs_port_props props_u (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .prdata_ff, .pready_ff, .pslverr_ff,
    .general_port_lines_out, .general_port_lines_oe, .port3_line1, .port3_line6_out_ff,
    .port3_line6_oe_ff, .cmp_enable_ff, .cmp_result_out_ff, .port_low_emi_ff, .osc_low_emi_ff,
    .ext_timing_ff
);

// ===== bench/ext_device.sv
module ext_device (
    // Clock
    input  logic       pclk,
    // Port pins
    input  logic [7:0] lines_out,
    input  logic [7:0] lines_oe,
    output logic [7:0] lines_in,
    // Handshake
    input  logic       line6,
    output logic       line1,
    // Bench control
    input  logic       rx_mode,
    input  logic       send_req,
    input  logic [7:0] send_data,
    input  logic [3:0] delay,
    output logic [7:0] got_data
);
    timeunit 1ns;
    timeprecision 1ps;
    logic       drv_en;
    logic [7:0] drv_val;

    // ====================
    // Pins
    // Pull-ups on every line, so released lines read high
    assign lines_in = (lines_oe & lines_out) | (~lines_oe & (drv_en ? drv_val : 8'hff));

    // ====================
    // Handshake peer
    initial begin
        line1 = 1'b1;
        drv_en = 1'b0;
        drv_val = 8'h00;
        got_data = 8'h00;
        forever begin
            @(posedge pclk);
            if (rx_mode && !line6 && line1) begin
                repeat (delay) @(posedge pclk);
                got_data <= lines_in;
                line1 <= 1'b0;
                while (!line6) @(posedge pclk);
                line1 <= 1'b1;
            end else if (!rx_mode && send_req && !line6) begin
                drv_en <= 1'b1;
                drv_val <= send_data;
                repeat (delay) @(posedge pclk);
                @(posedge pclk);
                line1 <= 1'b0;
                while (!line6) @(posedge pclk);
                line1 <= 1'b1;
                drv_en <= 1'b0;
            end
        end
    end
endmodule // ext_device

// ===== bench/hs_port_tb.sv
`include "hs_port_regs.vh"

module hs_port_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        pclk, presetn, psel, penable, pwrite, port3_line0, cmp1, cmp2, rx_mode, send_req;
    logic        pready, pslverr, line1, line6, osc_emi, ext_t, cmp_en, p30k, err;
    logic [7:0]  paddr, port0_in, send_data, got_data, pins, lout, loe, p0k;
    logic [31:0] pwdata, prdata, q;
    logic [3:0]  emi, delay;
    logic [1:0]  cmp_res;
    int          error_cnt = 0, num_checks = 0, cyc = 0, n, lat[2];

    hs_port dut_u (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata_ff(prdata), .pready_ff(pready), .pslverr_ff(pslverr),
        .general_port_lines_in(pins), .general_port_lines_out(lout), .general_port_lines_oe(loe),
        .general_port_keep(), .port0_in, .port0_keep(p0k), .port3_line0, .port3_line0_keep(p30k),
        .port3_line1(line1), .port3_line6_out_ff(line6), .port3_line6_oe_ff(),
        .cmp_line1_gt_ref(cmp1), .cmp_line2_gt_ref(cmp2), .cmp_enable_ff(cmp_en),
        .cmp_result_out_ff(cmp_res), .port_low_emi_ff(emi), .osc_low_emi_ff(osc_emi), .ext_timing_ff(ext_t)
    );

    ext_device dev_u (
        .pclk, .lines_out(lout), .lines_oe(loe), .lines_in(pins), .line6, .line1,
        .rx_mode, .send_req, .send_data, .delay, .got_data
    );

    // ====================
    // Tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Only pready or the bench timeout ends this wait
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // Pad and mode flops settle one edge after the write lands
        repeat (2) @(posedge pclk);
    endtask

    task automatic close_out();
        if (error_cnt == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // ====================
    // Clock and timeout
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            error_cnt++;
            close_out();
        end
    end

    // ====================
    // Scenarios
    initial begin
        {presetn, psel, penable, pwrite, cmp1, cmp2, rx_mode, send_req} = 8'h00;
        {paddr, pwdata, send_data, delay} = 52'h0;
        port0_in = 8'h5a;
        port3_line0 = 1'b1;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk(32'(loe), 32'h0);
        apb(1'b0, `PORT_DIR_OFS, 32'h0);
        chk(q, 32'hff);
        apb(1'b0, 8'h1c, 32'h0);
        chk(32'(err), 32'h1);
        apb(1'b0, `PORT_CFG_OFS, 32'h0);
        chk({q[30:0], err}, 32'h0);
        chk(32'({p0k, p30k}), 32'hb5);
        apb(1'b1, `PORT_DIR_OFS, 32'h0f);
        apb(1'b1, `PORT_OUT_OFS, 32'ha5);
        chk(32'({lout & loe, loe}), 32'ha0f0);
        apb(1'b0, `PORT_IN_OFS, 32'h0);
        chk(q, 32'haf);
        apb(1'b1, `PORT_CFG_OFS, 32'h02);
        chk(32'(loe), 32'h50);
        apb(1'b0, `PORT_IN_OFS, 32'h0);
        chk(q, 32'haf);
        // bench clock stands in for a crystal kept in range by the system
        for (int i = 0; i < 5; i++) begin
            apb(1'b1, `PORT_CFG_OFS, 32'h4 << i);
            chk(32'({osc_emi, emi}), 32'h1 << i);
        end
        cmp2 <= 1'b1;
        apb(1'b1, `PORT_CFG_OFS, 32'h81);
        chk(32'({cmp_en, cmp_res}), 32'h6);
        apb(1'b0, `STATUS_OFS, 32'h0);
        chk(32'(q[4:3]), 32'h2);
        apb(1'b1, `PORT_CFG_OFS, 32'h0);
        // Output handshake, plain then extended timing with a slow peer
        apb(1'b1, `PORT_DIR_OFS, 32'h0);
        rx_mode <= 1'b1;
        for (int e = 0; e < 2; e++) begin
            apb(1'b1, `HS_CTRL_OFS, 32'(1 + 2 * e));
            apb(1'b0, `STATUS_OFS, 32'h0);
            chk(32'(q[0]), 32'h1);
            delay <= 4'(3 * e);
            apb(1'b1, `HS_DATA_OFS, 32'h3c + 32'(e));
            n = 0;
            while (line6 !== 1'b0 && n < 50) begin
                @(posedge pclk);
                n++;
            end
            lat[e] = n;
            n = 0;
            do begin
                apb(1'b0, `STATUS_OFS, 32'h0);
                n++;
            end while (q[2] && n < 40);
            chk(32'(got_data), 32'h3c + 32'(e));
            chk(32'(ext_t), 32'(e));
        end
        chk(32'(lat[1] - lat[0]), 32'h2);
        // Input handshake, prompt then slow peer
        rx_mode <= 1'b0;
        apb(1'b1, `PORT_DIR_OFS, 32'hff);
        apb(1'b1, `HS_CTRL_OFS, 32'h1);
        apb(1'b0, `STATUS_OFS, 32'h0);
        chk(32'(q[0]), 32'h0);
        for (int k = 0; k < 2; k++) begin
            send_data <= 8'h96 ^ 8'(k);
            delay <= 4'(5 * k);
            send_req <= 1'b1;
            n = 0;
            do begin
                apb(1'b0, `STATUS_OFS, 32'h0);
                n++;
            end while (!q[1] && n < 40);
            send_req <= 1'b0;
            apb(1'b0, `HS_DATA_OFS, 32'h0);
            chk(q, 32'h96 ^ 32'(k));
            apb(1'b0, `STATUS_OFS, 32'h0);
            chk(32'(q[1]), 32'h0);
        end
        close_out();
    end
endmodule // hs_port_tb
